// ### include/sbd_pkg.sv
`default_nettype none

package sbd_pkg;

  localparam int DATA_W = 8;
  localparam int NIBBLE_W = 4;

  // Step taken by both decrement-skip instructions.
  localparam logic [7:0] DEC_STEP = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Values after reset.
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic MEM_WR_RESET = 1'b0;

  // Instruction cycles, for reference by the sequencer.
  localparam int CYCLES_NO_SKIP = 1;
  localparam int CYCLES_SKIP = 2;

  // Operation codes issued by the sequencer to this datapath.
  typedef enum logic [1:0] {
    OP_NONE,
    OP_SUB_BORROW_MEM,
    OP_DEC_SKIP_MEM,
    OP_DEC_SKIP_ACC
  } sbd_op_e;

  // Sequencing state: normal run, or discarding the next instruction.
  typedef enum logic {
    SEQ_RUN,
    SEQ_SKIP
  } sbd_seq_e;

endpackage : sbd_pkg

`default_nettype wire

// ### sim/sbd_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

// Data memory beside the datapath; reads forward a write-back still in flight.
module sbd_mem_model (
  input wire logic ref_clk,
  input wire logic clkEn,
  input wire logic instValid,
  input wire logic [1:0] addr,
  input wire logic memWrEn,
  input wire logic [7:0] memWrData,
  output logic [7:0] memRdData
);
  logic [7:0] mem [4];
  logic [1:0] wrAddr;

  // The bench preloads cells directly, so this is not an always_ff.
  always @(posedge ref_clk) begin
    if (clkEn && instValid) begin
      wrAddr <= addr;
    end
    if (clkEn && memWrEn) begin
      mem[wrAddr] <= memWrData;
    end
  end

  // Without forwarding a back-to-back read would see the stale byte.
  assign memRdData = (memWrEn && wrAddr == addr) ? memWrData : mem[addr];
endmodule : sbd_mem_model

`default_nettype wire

// ### sim/sub_borrow_and_decrement_skip_tb.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end

module sub_borrow_and_decrement_skip_tb;
  logic ref_clk = 1'h0;
  logic srst = 1'h1;
  logic clkEn = 1'h1;
  logic instValid = 1'h0;
  sbd_pkg::sbd_op_e instOp = sbd_pkg::OP_NONE;
  logic [1:0] addr = 2'h0;
  logic accLoadEn = 1'h0;
  logic [7:0] accLoadData = 8'h00;
  logic [7:0] memRdData, memWrData, accumulator;
  logic memWrEn, ovf, zf, acf, cf, scf, czf, skipActive;
  logic [5:0] flags;
  logic expC = 1'h0;
  logic expZ = 1'h0;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [15:0] subTab [6] = '{16'h1005, 16'h1020, 16'h100f, 16'h3333, 16'h8001, 16'h7fff};
  logic [7:0] decTab [3] = '{8'h01, 8'h05, 8'h00};

  assign flags = {ovf, zf, acf, cf, scf, czf};

  sbd_exec sbd_exec_i (
    .ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .instValid(instValid),
    .instOp(instOp), .memRdData(memRdData), .accLoadEn(accLoadEn),
    .accLoadData(accLoadData), .memWrEn(memWrEn), .memWrData(memWrData),
    .accumulator(accumulator), .overflow_flag(ovf), .zeroFlag(zf),
    .auxiliary_carry_flag(acf), .carryFlag(cf), .signed_compare_flag(scf),
    .combined_zero_flag(czf), .skipActive(skipActive));

  sbd_mem_model sbd_mem_model_i (
    .ref_clk(ref_clk), .clkEn(clkEn), .instValid(instValid), .addr(addr),
    .memWrEn(memWrEn), .memWrData(memWrData), .memRdData(memRdData));

  //////////////////////////////////////////////////////////////////////////////

  task automatic step(input logic v, input sbd_pkg::sbd_op_e op, input logic [1:0] a);
    @(negedge ref_clk);
    instValid = v;
    instOp = op;
    addr = a;
    accLoadEn = 1'h0;
    @(posedge ref_clk);
    #1;
  endtask : step

  task automatic load(input logic [7:0] a);
    @(negedge ref_clk);
    instValid = 1'h0;
    accLoadEn = 1'h1;
    accLoadData = a;
    @(posedge ref_clk);
  endtask : load

  task automatic sub(input logic [7:0] a, input logic [7:0] m);
    logic [8:0] d;
    logic [4:0] l;
    logic [7:0] r;
    logic ov;
    logic z;
    d = {1'h0, a} - {1'h0, m} - {8'h00, ~expC};
    l = {1'h0, a[3:0]} - {1'h0, m[3:0]} - {4'h0, ~expC};
    r = d[7:0];
    ov = (a[7] != m[7]) && (r[7] != a[7]);
    z = (r == 8'h00);
    sbd_mem_model_i.mem[1] = m;
    load(a);
    step(1'h1, sbd_pkg::OP_SUB_BORROW_MEM, 2'h1);
    `CHK(accumulator, a)
    `CHK(memWrEn, 1'h1)
    `CHK(memWrData, r)
    `CHK(cf, ~d[8])
    `CHK(acf, ~l[4])
    `CHK(ovf, ov)
    `CHK(zf, z)
    `CHK(scf, ov ^ r[7])
    `CHK(czf, z & expZ)
    expC = ~d[8];
    expZ = z;
    step(1'h0, sbd_pkg::OP_NONE, 2'h0);
    `CHK(memWrEn, 1'h0)
    `CHK(sbd_mem_model_i.mem[1], r)
  endtask : sub

  // The follower is the other decrement, on 42h, so a 41h anywhere shows it was not discarded.
  task automatic dec(input sbd_pkg::sbd_op_e op, input logic [7:0] m);
    logic [7:0] r;
    logic [7:0] acc0;
    logic [5:0] fl;
    logic runs;
    logic toAcc;
    r = m - 8'h01;
    runs = (r != 8'h00);
    toAcc = (op == sbd_pkg::OP_DEC_SKIP_MEM);
    sbd_mem_model_i.mem[0] = m;
    sbd_mem_model_i.mem[3] = 8'h42;
    step(1'h1, op, 2'h0);
    fl = flags;
    acc0 = accumulator;
    `CHK(skipActive, r == 8'h00)
    `CHK(memWrEn, op == sbd_pkg::OP_DEC_SKIP_MEM)
    if (op == sbd_pkg::OP_DEC_SKIP_MEM) begin
      `CHK(memWrData, r)
    end else begin
      `CHK(accumulator, r)
    end
    if (toAcc) begin
      step(1'h1, sbd_pkg::OP_DEC_SKIP_ACC, 2'h3);
    end else begin
      step(1'h1, sbd_pkg::OP_DEC_SKIP_MEM, 2'h3);
    end
    `CHK(accumulator, (runs && toAcc) ? 8'h41 : acc0)
    `CHK(flags, fl)
    `CHK(memWrEn, runs && !toAcc)
    step(1'h0, sbd_pkg::OP_NONE, 2'h0);
    `CHK(skipActive, 1'h0)
    `CHK(sbd_mem_model_i.mem[0], (op == sbd_pkg::OP_DEC_SKIP_MEM) ? r : m)
    `CHK(sbd_mem_model_i.mem[3], (runs && !toAcc) ? 8'h41 : 8'h42)
  endtask : dec

  // A 01h operand would zero the accumulator and arm a skip if the enable leaked through.
  task automatic freeze();
    logic [7:0] a0;
    a0 = accumulator;
    sbd_mem_model_i.mem[2] = 8'h01;
    @(negedge ref_clk);
    clkEn = 1'h0;
    step(1'h1, sbd_pkg::OP_DEC_SKIP_ACC, 2'h2);
    `CHK(accumulator, a0)
    `CHK(skipActive, 1'h0)
    step(1'h0, sbd_pkg::OP_NONE, 2'h0);
    @(negedge ref_clk);
    clkEn = 1'h1;
  endtask : freeze

  task automatic results();
    $display("Compared %0d, mismatched %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  //////////////////////////////////////////////////////////////////////////////

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // A hang is cut short here and reported as a mismatch.
  initial begin
    #200000;
    n_mismatch++;
    results();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    srst = 1'h0;
    `CHK({memWrEn, memWrData, accumulator, flags, skipActive}, 24'h000000)
    for (int i = 0; i < 6; i++) begin
      sub(subTab[i][15:8], subTab[i][7:0]);
    end
    for (int i = 0; i < 6; i++) begin
      dec(sbd_pkg::sbd_op_e'((i < 3) ? sbd_pkg::OP_DEC_SKIP_MEM : sbd_pkg::OP_DEC_SKIP_ACC),
          decTab[i % 3]);
    end
    freeze();
    results();
  end
endmodule : sub_borrow_and_decrement_skip_tb

`default_nettype wire

// ### src/sbd_exec.sv
`timescale 1ns/100ps
`default_nettype none

module sbd_exec #(
  parameter int WIDTH = sbd_pkg::DATA_W
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic instValid,
  input wire sbd_pkg::sbd_op_e instOp,
  input wire logic [WIDTH-1:0] memRdData,
  input wire logic accLoadEn,
  input wire logic [WIDTH-1:0] accLoadData,
  output logic memWrEn,
  output logic [WIDTH-1:0] memWrData,
  output logic [WIDTH-1:0] accumulator,
  output logic overflow_flag,
  output logic zeroFlag,
  output logic auxiliary_carry_flag,
  output logic carryFlag,
  output logic signed_compare_flag,
  output logic combined_zero_flag,
  output logic skipActive
);

  sbd_pkg::sbd_seq_e stateReg;
  sbd_pkg::sbd_seq_e stateNext;
  logic [WIDTH-1:0] accReg;
  logic memWrEnReg;
  logic [WIDTH-1:0] memWrDataReg;
  logic ovReg, zReg, acReg, cReg, scReg, czReg;

  logic take;
  logic executing;
  logic swallow;
  logic isSub;
  logic isDecMem;
  logic isDecAcc;
  logic isDec;
  logic [WIDTH-1:0] decResult;
  logic decZero;

  logic [WIDTH-1:0] subResult;
  logic subCarry, subAux, subOv, subZero, subSc, subCz;

  //////////////////////////////////////////////////////////////////////////////
  // Instruction acceptance and decode.

  assign take = clkEn & instValid;
  assign executing = take & (stateReg == sbd_pkg::SEQ_RUN);
  // The instruction fetched during the dummy cycle is dropped here.
  assign swallow = take & (stateReg == sbd_pkg::SEQ_SKIP);
  assign isSub = executing & (instOp == sbd_pkg::OP_SUB_BORROW_MEM);
  assign isDecMem = executing & (instOp == sbd_pkg::OP_DEC_SKIP_MEM);
  assign isDecAcc = executing & (instOp == sbd_pkg::OP_DEC_SKIP_ACC);
  assign isDec = isDecMem | isDecAcc;

  // Plain width-limited subtraction wraps, so 00 gives ff and never skips.
  assign decResult = memRdData - sbd_pkg::DEC_STEP;
  assign decZero = (decResult == sbd_pkg::ZERO_BYTE);

  //////////////////////////////////////////////////////////////////////////////
  // Arithmetic.

  sbd_sub_borrow #(
    .WIDTH(WIDTH)
  ) sbd_sub_borrow_i (
    .minuend(accReg),
    .subtrahend(memRdData),
    .carryIn(cReg),
    .combinedZeroIn(zReg),
    .result(subResult),
    .carryOut(subCarry),
    .auxCarryOut(subAux),
    .overflowOut(subOv),
    .zeroOut(subZero),
    .signedCompareOut(subSc),
    .combinedZeroOut(subCz)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Sequencing: a zero decrement result arms one dummy cycle.

  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      sbd_pkg::SEQ_RUN: begin
        if (isDec && decZero) begin
          stateNext = sbd_pkg::SEQ_SKIP;
        end
      end
      sbd_pkg::SEQ_SKIP: begin
        // Waiting here keeps the skip pending until the next fetch arrives.
        if (take) begin
          stateNext = sbd_pkg::SEQ_RUN;
        end
      end
      default: begin
        stateNext = sbd_pkg::SEQ_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stateReg <= sbd_pkg::SEQ_RUN;
    end else if (clkEn) begin
      stateReg <= stateNext;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Memory write-back.

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      memWrEnReg <= sbd_pkg::MEM_WR_RESET;
      memWrDataReg <= sbd_pkg::ACC_RESET;
    end else if (clkEn) begin
      memWrEnReg <= isSub | isDecMem;
      if (isSub) begin
        memWrDataReg <= subResult;
      end else if (isDecMem) begin
        memWrDataReg <= decResult;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Accumulator.

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      accReg <= sbd_pkg::ACC_RESET;
    end else if (clkEn) begin
      if (isDecAcc) begin
        accReg <= decResult;
      end else if (accLoadEn && !swallow) begin
        // Loads are dropped in the cycle in which the skipped instruction is taken, and when a decrement-to-accumulator executes.
        accReg <= accLoadData;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status flags. Decrement-skip instructions leave every flag alone.

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ovReg <= sbd_pkg::FLAG_RESET;
      zReg <= sbd_pkg::FLAG_RESET;
      acReg <= sbd_pkg::FLAG_RESET;
      cReg <= sbd_pkg::FLAG_RESET;
      scReg <= sbd_pkg::FLAG_RESET;
      czReg <= sbd_pkg::FLAG_RESET;
    end else if (clkEn && isSub) begin
      ovReg <= subOv;
      zReg <= subZero;
      acReg <= subAux;
      cReg <= subCarry;
      scReg <= subSc;
      czReg <= subCz;
    end
  end

  assign memWrEn = memWrEnReg;
  assign memWrData = memWrDataReg;
  assign accumulator = accReg;
  assign overflow_flag = ovReg;
  assign zeroFlag = zReg;
  assign auxiliary_carry_flag = acReg;
  assign carryFlag = cReg;
  assign signed_compare_flag = scReg;
  assign combined_zero_flag = czReg;
  assign skipActive = (stateReg == sbd_pkg::SEQ_SKIP);

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  sequence s_subIssue;
    isSub;
  endsequence

  sequence s_zeroDec;
    isDec && (memRdData == sbd_pkg::DEC_STEP);
  endsequence

  sequence s_dummyFetch;
    skipActive && take;
  endsequence

  a_sub_write_back: assert property (
    s_subIssue |=> memWrEn && (memWrData == $past(accReg) - $past(memRdData)
                               - {{(WIDTH-1){1'b0}}, !$past(cReg)}))
    else $error("subtract-with-borrow result not written to memory");

  a_sub_carry_sign: assert property (
    s_subIssue |=> carryFlag == ({1'b0, $past(accReg)} >=
                                 {1'b0, $past(memRdData)} + {{WIDTH{1'b0}}, !$past(cReg)}))
    else $error("carry does not reflect sign of subtraction");

  a_sub_zero_flags: assert property (
    s_subIssue |=> (zeroFlag == (memWrData == sbd_pkg::ZERO_BYTE))
                   && (signed_compare_flag == (overflow_flag ^ memWrData[WIDTH-1]))
                   && (combined_zero_flag == (zeroFlag && $past(zReg))))
    else $error("status flags inconsistent with subtraction result");

  a_dec_mem_write: assert property (
    isDecMem |=> memWrEn && (memWrData == $past(memRdData) - sbd_pkg::DEC_STEP))
    else $error("decrement not written back to memory");

  a_dec_zero_skip: assert property (
    s_zeroDec |=> skipActive)
    else $error("zero decrement result did not arm a skip");

  a_dummy_cycle_end: assert property (
    s_zeroDec ##1 s_dummyFetch |=> !skipActive && !memWrEn)
    else $error("dummy cycle did not end after one fetch");

  a_dec_no_skip: assert property (
    isDec && (memRdData != sbd_pkg::DEC_STEP) |=> !skipActive)
    else $error("nonzero decrement result skipped");

  a_dec_acc_only: assert property (
    isDecAcc |=> !memWrEn && (accumulator == $past(memRdData) - sbd_pkg::DEC_STEP))
    else $error("decrement-to-accumulator wrong or wrote memory");

  a_skip_no_effect: assert property (
    s_dummyFetch |=> !memWrEn && $stable(accumulator) && $stable(carryFlag)
                     && $stable(zeroFlag) && $stable(overflow_flag))
    else $error("skipped instruction changed state");

  a_dec_wrap_ff: assert property (
    isDec && (memRdData == sbd_pkg::ZERO_BYTE) |=> !skipActive
      && ((memWrEn && memWrData == {WIDTH{1'b1}}) || (accumulator == {WIDTH{1'b1}})))
    else $error("decrement of zero did not wrap to all ones");

endmodule : sbd_exec

`default_nettype wire

// ### src/sbd_sub_borrow.sv
`timescale 1ns/100ps
`default_nettype none

// Subtract with borrow: result = a - b - not(carryIn), flags from the result.
module sbd_sub_borrow #(
  parameter int WIDTH = sbd_pkg::DATA_W
) (
  input wire logic [WIDTH-1:0] minuend,
  input wire logic [WIDTH-1:0] subtrahend,
  input wire logic carryIn,
  input wire logic combinedZeroIn,
  output logic [WIDTH-1:0] result,
  output logic carryOut,
  output logic auxCarryOut,
  output logic overflowOut,
  output logic zeroOut,
  output logic signedCompareOut,
  output logic combinedZeroOut
);

  localparam int NW = sbd_pkg::NIBBLE_W;

  logic [WIDTH:0] fullSum;
  logic [NW:0] lowSum;

  // Adding the inverted subtrahend gives a carry of 1 exactly when no borrow occurs.
  assign fullSum = {1'b0, minuend} + {1'b0, ~subtrahend} + {{WIDTH{1'b0}}, carryIn};
  assign lowSum = {1'b0, minuend[NW-1:0]} + {1'b0, ~subtrahend[NW-1:0]} + {{NW{1'b0}}, carryIn};

  assign result = fullSum[WIDTH-1:0];
  assign carryOut = fullSum[WIDTH];
  assign auxCarryOut = lowSum[NW];
  assign overflowOut = (minuend[WIDTH-1] ^ subtrahend[WIDTH-1])
                     & (minuend[WIDTH-1] ^ fullSum[WIDTH-1]);
  assign zeroOut = (fullSum[WIDTH-1:0] == '0);
  assign signedCompareOut = overflowOut ^ fullSum[WIDTH-1];
  // Combined zero is set only when this byte and the previous subtraction's zero flag (zReg, not the combined flag) were zero.
  assign combinedZeroOut = zeroOut & combinedZeroIn;

endmodule : sbd_sub_borrow

`default_nettype wire
